// >>> verilog/rf_frontend_defines.svh
`ifndef RF_FRONTEND_DEFINES_SVH
`define RF_FRONTEND_DEFINES_SVH
// ==========================================================
// register offsets
`define OFS_RX_FRONTEND 16'hdf1a
`define OFS_TX_FRONTEND 16'hdf1b
`define OFS_CAL_CTRL 16'hdf1c
`define OFS_CAL_MID 16'hdf1d
`define OFS_CAL_LOW 16'hdf1e
`define OFS_TABLE_BASE 16'hdf27
`define OFS_TX_CTRL 16'hdf40
// ==========================================================
// reset values
`define RST_RX_FRONTEND 8'h56
`define RST_LO_BUF 2'b01
`define RST_POWER_IDX 3'b000
`define RST_CAL_CFG 2'b10
`define RST_PUMP_EN 2'b10
`define RST_CAL_HI 4'b1001
`define RST_CAL_MID 6'h0a
`define RST_CAL_LOW 6'h02
`define RST_TABLE 8'h00
// ==========================================================
// timing
`define RAMP_STEP_CYCLES 8'd40
`endif

// >>> verilog/rf_frontend_pkg.sv
package rf_frontend_pkg;
  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_UP = 2'b01,
    RAMP_HOLD = 2'b10,
    RAMP_DOWN = 2'b11
  } ramp_state_t;

  typedef struct packed {
    logic [1:0] lo_buf;
    logic [2:0] power_idx;
  } tx_cfg_t;

  typedef struct packed {
    logic [1:0] cal_cfg;
    logic [1:0] pump_en;
    logic [3:0] cal_hi;
    logic [5:0] cal_mid;
    logic [5:0] cal_low;
  } cal_t;
endpackage : rf_frontend_pkg

// >>> verilog/power_ramp.sv
`timescale 1ns/1ps
`default_nettype none
`include "rf_frontend_defines.svh"
module power_ramp
  import rf_frontend_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic tx_active,
  input wire logic ask_mode,
  input wire logic tx_symbol,
  input wire logic [2:0] power_idx,
  output logic [2:0] sel,
  output logic ramp_busy
);
  ramp_state_t state, next_state;
  logic [2:0] next_sel;
  logic [7:0] tick, next_tick;
  logic step;

  // ==========================================================
  // ramp sequencer
  // one step per RAMP_STEP_CYCLES ticks keeps the amplifier settle time fixed
  always_comb begin
    next_state = state;
    next_sel = sel;
    step = (tick == `RAMP_STEP_CYCLES - 8'd1);
    next_tick = step ? 8'd0 : tick + 8'd1;
    case (state)
      RAMP_IDLE: begin
        next_tick = 8'd0;
        next_sel = 3'd0;
        if (tx_active) next_state = RAMP_UP;
      end
      RAMP_UP: begin
        if (!tx_active) next_state = RAMP_DOWN;
        else if (sel == power_idx) next_state = RAMP_HOLD;
        else if (step) next_sel = sel + 3'd1;
      end
      RAMP_HOLD: begin
        next_tick = 8'd0;
        if (!tx_active) next_state = RAMP_DOWN;
        else if (ask_mode) next_sel = tx_symbol ? power_idx : 3'd0;
        else next_sel = power_idx;
      end
      default: begin
        if (sel == 3'd0) next_state = tx_active ? RAMP_UP : RAMP_IDLE;
        else if (step) next_sel = sel - 3'd1;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= RAMP_IDLE;
      sel <= 3'd0;
      tick <= 8'd0;
      ramp_busy <= 1'b0;
    end else begin
      state <= next_state;
      sel <= next_sel;
      tick <= next_tick;
      ramp_busy <= (next_state == RAMP_UP) || (next_state == RAMP_DOWN);
    end
  end
endmodule : power_ramp
`default_nettype wire

// >>> verilog/rf_frontend_synth_cal_regs.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "rf_frontend_defines.svh"
module rf_frontend_synth_cal_regs
  import rf_frontend_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic tx_symbol,
  output logic [7:0] pa_setting,
  output logic [3:0] pa_index,
  output logic pump_cal_skip,
  output logic [7:0] rx_frontend_out,
  output logic [1:0] lo_buf_out,
  output cal_t cal_out
);
  logic [7:0] rx_frontend_config, next_rx;
  tx_cfg_t tx_cfg, next_tx_cfg;
  cal_t cal, next_cal;
  logic [7:0] power_level_table [0:7];
  logic [7:0] next_table [0:7];
  logic tx_en, next_tx_en;
  logic ask_en, next_ask_en;
  logic [7:0] next_rdata;
  logic [2:0] sel;
  logic busy;

  // table entries are stored in descending address order
  function automatic logic is_table(input logic [15:0] a);
    is_table = (a >= `OFS_TABLE_BASE) && (a <= `OFS_TABLE_BASE + 16'd7);
  endfunction : is_table

  function automatic logic [2:0] table_slot(input logic [15:0] a);
    logic [15:0] d;
    d = `OFS_TABLE_BASE + 16'd7 - a;
    table_slot = d[2:0];
  endfunction : table_slot

  // ==========================================================
  // register writes
  always_comb begin
    next_rx = rx_frontend_config;
    next_tx_cfg = tx_cfg;
    next_cal = cal;
    next_tx_en = tx_en;
    next_ask_en = ask_en;
    for (int i = 0; i < 8; i++) begin
      next_table[i] = power_level_table[i];
    end
    if (wr) begin
      if (addr == `OFS_RX_FRONTEND) begin
        next_rx = wdata;
      end else if (addr == `OFS_TX_FRONTEND) begin
        // bits 7:6 and 3 are dropped
        next_tx_cfg.lo_buf = wdata[5:4];
        next_tx_cfg.power_idx = wdata[2:0];
      end else if (addr == `OFS_CAL_CTRL) begin
        next_cal.cal_cfg = wdata[7:6];
        next_cal.pump_en = wdata[5:4];
        next_cal.cal_hi = wdata[3:0];
      end else if (addr == `OFS_CAL_MID) begin
        next_cal.cal_mid = wdata[5:0];
      end else if (addr == `OFS_CAL_LOW) begin
        next_cal.cal_low = wdata[5:0];
      end else if (is_table(addr)) begin
        next_table[table_slot(addr)] = wdata;
      end else if (addr == `OFS_TX_CTRL) begin
        next_tx_en = wdata[0];
        next_ask_en = wdata[1];
      end
    end
  end

  // ==========================================================
  // read mux, data valid the cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (rd) begin
      if (addr == `OFS_RX_FRONTEND) begin
        next_rdata = rx_frontend_config;
      end else if (addr == `OFS_TX_FRONTEND) begin
        next_rdata = {2'b00, tx_cfg.lo_buf, 1'b0, tx_cfg.power_idx};
      end else if (addr == `OFS_CAL_CTRL) begin
        next_rdata = {cal.cal_cfg, cal.pump_en, cal.cal_hi};
      end else if (addr == `OFS_CAL_MID) begin
        next_rdata = {2'b00, cal.cal_mid};
      end else if (addr == `OFS_CAL_LOW) begin
        next_rdata = {2'b00, cal.cal_low};
      end else if (is_table(addr)) begin
        next_rdata = power_level_table[table_slot(addr)];
      end else if (addr == `OFS_TX_CTRL) begin
        // busy bit shows the live ramp state
        next_rdata = {5'b00000, busy, ask_en, tx_en};
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_frontend_config <= `RST_RX_FRONTEND;
      tx_cfg.lo_buf <= `RST_LO_BUF;
      tx_cfg.power_idx <= `RST_POWER_IDX;
      cal.cal_cfg <= `RST_CAL_CFG;
      cal.pump_en <= `RST_PUMP_EN;
      cal.cal_hi <= `RST_CAL_HI;
      cal.cal_mid <= `RST_CAL_MID;
      cal.cal_low <= `RST_CAL_LOW;
      tx_en <= 1'b0;
      ask_en <= 1'b0;
      rdata <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        power_level_table[i] <= `RST_TABLE;
      end
    end else begin
      rx_frontend_config <= next_rx;
      tx_cfg <= next_tx_cfg;
      cal <= next_cal;
      tx_en <= next_tx_en;
      ask_en <= next_ask_en;
      rdata <= next_rdata;
      for (int i = 0; i < 8; i++) begin
        power_level_table[i] <= next_table[i];
      end
    end
  end

  // ==========================================================
  // power ramp and ASK level selection
  power_ramp u_ramp (
    .mclk(mclk),
    .rst(rst),
    .tx_active(tx_en),
    .ask_mode(ask_en),
    .tx_symbol(tx_symbol),
    .power_idx(tx_cfg.power_idx),
    .sel(sel),
    .ramp_busy(busy)
  );

  // ==========================================================
  // registered outputs toward the analog side
  // one cycle behind sel; acceptable against analog settle times
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pa_setting <= `RST_TABLE;
      pa_index <= 4'h0;
      pump_cal_skip <= 1'b0;
      rx_frontend_out <= `RST_RX_FRONTEND;
      lo_buf_out <= `RST_LO_BUF;
      // copy starts at the field reset values, in step with pump_cal_skip
      cal_out <= {`RST_CAL_CFG, `RST_PUMP_EN, `RST_CAL_HI, `RST_CAL_MID,
        `RST_CAL_LOW};
    end else begin
      pa_setting <= power_level_table[sel];
      pa_index <= {tx_en, sel};
      pump_cal_skip <= (cal.pump_en == 2'b00);
      rx_frontend_out <= rx_frontend_config;
      lo_buf_out <= tx_cfg.lo_buf;
      cal_out <= cal;
    end
  end
endmodule : rf_frontend_synth_cal_regs
`default_nettype wire

// >>> tb/rf_frontend_synth_cal_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker for the register bank
module regs_checker
  import rf_frontend_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic pump_cal_skip,
  input wire logic [7:0] rx_frontend_out,
  input wire logic [1:0] lo_buf_out,
  input wire logic [3:0] pa_index,
  input wire cal_t cal_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // read data only stand in the cycle after a read
  property p_rd_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_tx_rsv;
    rd && addr == 16'hdf1b |=> rdata[7:6] == 2'b00 && !rdata[3];
  endproperty
  a_tx_rsv: assert property (p_tx_rsv) else $error("tx reserved set");
  property p_mid_rsv;
    rd && addr == 16'hdf1d |=> rdata[7:6] == 2'b00;
  endproperty
  a_mid_rsv: assert property (p_mid_rsv) else $error("mid reserved set");
  // copies lag the register by one cycle, hence two cycles
  property p_rx_wr;
    wr && addr == 16'hdf1a |-> ##2 rx_frontend_out == $past(wdata, 2);
  endproperty
  a_rx_wr: assert property (p_rx_wr) else $error("rx copy stale");
  property p_lo_wr;
    wr && addr == 16'hdf1b |-> ##2 lo_buf_out == $past(wdata[5:4], 2);
  endproperty
  a_lo_wr: assert property (p_lo_wr) else $error("lo copy stale");
  property p_mid_wr;
    wr && addr == 16'hdf1d |-> ##2 cal_out.cal_mid == $past(wdata[5:0], 2);
  endproperty
  a_mid_wr: assert property (p_mid_wr) else $error("mid copy stale");
  // flag and copy are taken from the same register on the same edge
  property p_skip;
    pump_cal_skip == (cal_out.pump_en == 2'b00);
  endproperty
  a_skip: assert property (p_skip) else $error("skip flag wrong");
  // with transmit off the slot may only fall one step at a time
  property p_ramp_dn;
    !pa_index[3] && pa_index[2:0] != $past(pa_index[2:0])
      |-> pa_index[2:0] == $past(pa_index[2:0]) - 3'd1;
  endproperty
  a_ramp_dn: assert property (p_ramp_dn) else $error("ramp jump");
endmodule : regs_checker
`default_nettype wire

// >>> tb/test_rf_frontend_synth_cal_regs.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench for the front-end register bank
module test_rf_frontend_synth_cal_regs;
  import rf_frontend_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tx_symbol = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, pa_setting, rx_frontend_out;
  logic [3:0] pa_index;
  logic [1:0] lo_buf_out;
  logic pump_cal_skip;
  cal_t cal_out;
  int n_mismatch = 0, num_checks = 0, cycles = 0;
  rf_frontend_synth_cal_regs dut (.mclk, .rst, .addr, .wdata, .wr, .rd,
    .rdata, .tx_symbol, .pa_setting, .pa_index, .pump_cal_skip,
    .rx_frontend_out, .lo_buf_out, .cal_out);
  initial forever #12.5 mclk = ~mclk;
  // the run takes under a thousand cycles, so this only cuts a hang
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end
  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic write(logic [15:0] a, logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : write
  // data are taken just after the edge that ends the strobe
  task automatic read(logic [15:0] a, logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 check($sformatf("reg %h", a), exp, rdata);
  endtask : read
  task automatic settle(int n, string name, logic [7:0] exp);
    repeat (n) @(posedge mclk);
    #1 check(name, exp, name == "slot" ? {4'h0, pa_index} : pa_setting);
  endtask : settle
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  // ==========================================
  // scenarios
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    read(16'hdf1a, 8'h56);
    read(16'hdf1b, 8'h10);
    read(16'hdf1c, 8'ha9);
    read(16'hdf1d, 8'h0a);
    read(16'hdf1e, 8'h02);
    read(16'hdf2e, 8'h00);
    write(16'hdf1f, 8'hff);
    read(16'hdf1f, 8'h00);
    write(16'hdf1a, 8'ha5);
    write(16'hdf1b, 8'hff);
    write(16'hdf1c, 8'h0f);
    write(16'hdf1d, 8'hff);
    write(16'hdf1e, 8'hc5);
    read(16'hdf1a, 8'ha5);
    read(16'hdf1b, 8'h37);
    read(16'hdf1c, 8'h0f);
    write(16'hdf1c, 8'h4f);
    read(16'hdf1c, 8'h4f);
    read(16'hdf1d, 8'h3f);
    read(16'hdf1e, 8'h05);
    check("skip", 8'h01, {7'h00, pump_cal_skip});
    check("lo", 8'h03, {6'h00, lo_buf_out});
    check("low", 8'h05, {2'b00, cal_out.cal_low});
    // entry k holds 0x10+k so the applied slot is visible
    for (int k = 0; k < 8; k++) write(16'hdf2e - 16'(k), 8'h10 + 8'(k));
    write(16'hdf1b, 8'h03);
    @(posedge mclk);
    tx_symbol <= 1'b1;
    write(16'hdf40, 8'h03);
    settle(5, "slot", 8'h08);
    settle(55, "slot", 8'h09);
    settle(100, "pa", 8'h13);
    @(posedge mclk);
    tx_symbol <= 1'b0;
    settle(3, "pa", 8'h10);
    write(16'hdf40, 8'h01);
    settle(3, "pa", 8'h13);
    write(16'hdf40, 8'h00);
    settle(60, "slot", 8'h02);
    settle(100, "pa", 8'h10);
    complete_run();
  end
endmodule : test_rf_frontend_synth_cal_regs
bind rf_frontend_synth_cal_regs regs_checker chk (.mclk, .rst, .addr, .wdata,
  .wr, .rd, .rdata, .pump_cal_skip, .rx_frontend_out, .lo_buf_out,
  .pa_index, .cal_out);
`default_nettype wire
